//--- burner_heat_cfg_pkg.sv
package burner_heat_cfg_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 16;
	// Register addresses of the bank.
	localparam logic [7:0] A_STANDBY_RATE = 8'hCF;
	localparam logic [7:0] A_HEAT_ENABLE = 8'hD0;
	localparam logic [7:0] A_DEMAND_SRC = 8'hD1;
	localparam logic [7:0] A_MOD_SENSOR = 8'hD2;
	localparam logic [7:0] A_SETPOINT = 8'hD3;
	localparam logic [7:0] A_TOD_SETPOINT = 8'hD4;
	localparam logic [7:0] A_ON_HYST = 8'hD5;
	localparam logic [7:0] A_OFF_HYST = 8'hD6;
	localparam logic [7:0] A_ODR_ENABLE = 8'hD7;
	localparam logic [7:0] A_P_GAIN = 8'hD8;
	localparam logic [7:0] A_I_GAIN = 8'hD9;
	localparam logic [7:0] A_D_GAIN = 8'hDA;
	localparam logic [7:0] A_HYST_STEP = 8'hDB;
	localparam logic [7:0] A_PRESS_SETPT = 8'hDC;
	localparam logic [7:0] A_PRESS_ON_HYST = 8'hDD;
	localparam logic [7:0] A_PRESS_OFF_HYST = 8'hDE;
	localparam logic [7:0] A_RSVD_DF = 8'hDF;
	localparam logic [7:0] A_IGN_SOURCE = 8'hE0;
	localparam logic [7:0] A_TERM_FUNC = 8'hE1;
	localparam logic [7:0] A_IGNITER_ON = 8'hE2;
	localparam logic [7:0] A_PILOT_TYPE = 8'hE3;
	localparam logic [7:0] A_FLAME_SENSOR = 8'hE4;
	localparam logic [7:0] A_PURGE_PROVE = 8'hE5;
	localparam logic [7:0] A_LIGHTOFF_PROVE = 8'hE6;
	localparam logic [7:0] A_PREPURGE = 8'hE7;
	localparam logic [7:0] A_PREIGNITION = 8'hE8;
	localparam logic [7:0] A_PILOT_WIN = 8'hE9;
	localparam logic [7:0] A_MAIN_WIN = 8'hEA;
	localparam logic [7:0] A_RUN_STAB = 8'hEB;
	localparam logic [7:0] A_POSTPURGE = 8'hEC;
	localparam logic [7:0] A_ILK_CHECK = 8'hED;
	localparam logic [7:0] A_ILK_RESP = 8'hEE;
	localparam logic [7:0] A_IGN_FAIL_RESP = 8'hEF;
	localparam logic [7:0] A_IGN_RETRIES = 8'hF0;
	localparam logic [7:0] A_IGN_FAIL_DELAY = 8'hF1;
	localparam logic [7:0] A_MAIN_FAIL_RESP = 8'hF2;
	localparam logic [7:0] A_RUN_FAIL_RESP = 8'hF3;
	localparam logic [7:0] A_PILOT_HOLD = 8'hF4;
	localparam logic [7:0] A_RSVD_F5 = 8'hF5;
	// Reset values and value limits.
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] NOT_CONFIGURED = 16'hFFFF;
	localparam logic [15:0] TIME_MAX_S = 16'hFD20;
	localparam logic [15:0] TEMP_MIN = 16'hFE70;
	localparam logic [15:0] TEMP_MAX = 16'h0514;
	localparam logic [15:0] GAIN_MAX = 16'h03E8;
	localparam logic [15:0] PRESS_MAX = 16'h05DC;
	// Decoded window lengths in seconds and retry counts.
	localparam logic [4:0] PILOT_WIN_1_S = 5'h04;
	localparam logic [4:0] MAIN_WIN_1_S = 5'h05;
	localparam logic [4:0] WIN_2_S = 5'h0A;
	localparam logic [4:0] WIN_3_S = 5'h0F;
	localparam logic [2:0] RETRY_CODE1 = 3'h3;
	localparam logic [2:0] RETRY_CODE2 = 3'h5;
	localparam logic [2:0] RETRY_CODE3 = 3'h1;

	typedef enum logic [7:0] {
		EXC_NONE = 8'h00,
		EXC_ADDR = 8'h02,
		EXC_VALUE = 8'h03
	} exc_e;

	typedef struct packed {
		logic valid;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic ack;
		exc_e exc;
		logic [DATA_W-1:0] rdata;
	} reg_rsp_s;

	typedef struct packed {
		logic heat_enable;
		logic [2:0] demand_src;
		logic [2:0] mod_sensor;
		logic [15:0] active_setpoint;
		logic outdoor_reset_en;
		logic hyst_step_en;
		logic [1:0] ign_source;
		logic term_is_igniter;
		logic igniter_half_window;
		logic [1:0] pilot_type;
		logic [1:0] flame_sensor;
		logic [1:0] lightoff_prove;
		logic [4:0] pilot_win_s;
		logic [4:0] main_win_s;
		logic windows_configured;
		logic timers_configured;
		logic ilk_start_check;
		logic ilk_open_recycle;
		logic main_fail_recycle;
		logic run_fail_recycle;
		logic [1:0] ign_fail_resp;
		logic [2:0] ign_retries;
		logic retries_configured;
	} heat_cfg_s;
endpackage

//--- burner_heat_config_regs.sv
`timescale 1ns/100ps
module burner_heat_config_regs
	import burner_heat_cfg_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// Register access from the serial protocol engine
	input wire reg_req_s i_req,
	output reg_rsp_s o_rsp,
	// Time-of-day switch and decoded configuration
	input wire logic i_tod_on,
	output heat_cfg_s o_cfg
);
	logic [15:0] regs [A_STANDBY_RATE:A_RSVD_F5];
	heat_cfg_s next_cfg;
	logic in_range;
	logic reserved;
	logic value_ok;
	logic [7:0] a8;

	function automatic logic is_reserved(input logic [7:0] a);
		return (a == A_RSVD_DF) || (a == A_RSVD_F5);
	endfunction

	function automatic logic [15:0] reset_value(input logic [7:0] a);
		unique case (a)
			A_PREPURGE, A_PREIGNITION, A_PILOT_WIN, A_MAIN_WIN, A_RUN_STAB,
			A_POSTPURGE, A_IGN_RETRIES, A_IGN_FAIL_DELAY:
				return NOT_CONFIGURED;
			default:
				return RST_ZERO;
		endcase
	endfunction

	function automatic logic timer_ok(input logic [15:0] d);
		return (d <= TIME_MAX_S) || (d == NOT_CONFIGURED);
	endfunction

	function automatic logic code_ok(input logic [15:0] d, input logic [15:0] top);
		return d <= top;
	endfunction

	// Values outside the documented encodings are refused.
	function automatic logic legal(input logic [7:0] a, input logic [15:0] d);
		unique case (a)
			A_HEAT_ENABLE, A_ODR_ENABLE, A_TERM_FUNC, A_IGNITER_ON, A_ILK_CHECK,
			A_ILK_RESP, A_MAIN_FAIL_RESP, A_RUN_FAIL_RESP, A_PILOT_HOLD:
				return code_ok(d, 16'h0001);
			A_DEMAND_SRC:
				return code_ok(d, 16'h0005) && (d != 16'h0004);
			A_MOD_SENSOR:
				return code_ok(d, 16'h0004) && (d != 16'h0001);
			A_SETPOINT, A_TOD_SETPOINT:
				return ($signed(d) >= $signed(TEMP_MIN)) && ($signed(d) <= $signed(TEMP_MAX));
			A_ON_HYST, A_OFF_HYST:
				return code_ok(d, TEMP_MAX);
			A_P_GAIN, A_I_GAIN, A_D_GAIN:
				return code_ok(d, GAIN_MAX);
			A_HYST_STEP:
				return code_ok(d, TIME_MAX_S);
			A_PRESS_SETPT, A_PRESS_ON_HYST, A_PRESS_OFF_HYST:
				return code_ok(d, PRESS_MAX);
			A_IGN_SOURCE, A_PURGE_PROVE:
				return code_ok(d, 16'h0002);
			A_PILOT_TYPE, A_FLAME_SENSOR, A_LIGHTOFF_PROVE, A_IGN_FAIL_RESP:
				return code_ok(d, 16'h0003);
			A_PILOT_WIN, A_MAIN_WIN, A_IGN_RETRIES:
				return code_ok(d, 16'h0003) || (d == NOT_CONFIGURED);
			A_PREPURGE, A_PREIGNITION, A_RUN_STAB, A_POSTPURGE, A_IGN_FAIL_DELAY:
				return timer_ok(d);
			default:
				return 1'b1;
		endcase
	endfunction

	function automatic logic [4:0] window_s(input logic [15:0] d, input logic [4:0] one_s);
		unique case (d)
			16'h0001: return one_s;
			16'h0002: return WIN_2_S;
			16'h0003: return WIN_3_S;
			default: return 5'h00;
		endcase
	endfunction

	assign a8 = i_req.addr[7:0];
	assign in_range = (i_req.addr[15:8] == 8'h00) && (a8 >= A_STANDBY_RATE) && (a8 <= A_RSVD_F5);
	assign reserved = is_reserved(a8);
	assign value_ok = legal(a8, i_req.wdata);

	// Register storage; one access per request, bursts arrive as a series.
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			for (int a = A_STANDBY_RATE; a <= A_RSVD_F5; a++) begin
				regs[a] <= reset_value(8'(a));
			end
		end else if (i_req.valid && i_req.wr && in_range && !reserved && value_ok) begin
			regs[a8] <= i_req.wdata;
		end
	end

	// Answer one cycle after each request.
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_rsp <= '{ack: 1'b0, exc: EXC_NONE, rdata: RST_ZERO};
		end else begin
			o_rsp.ack <= i_req.valid;
			o_rsp.rdata <= RST_ZERO;
			o_rsp.exc <= EXC_NONE;
			if (i_req.valid) begin
				if (!in_range) begin
					o_rsp.exc <= EXC_ADDR;
				end else if (i_req.wr) begin
					if (!reserved && !value_ok) begin
						o_rsp.exc <= EXC_VALUE;
					end
				end else if (!reserved) begin
					o_rsp.rdata <= regs[a8];
				end
			end
		end
	end

	// Decode the stored values for the heating loop and burner sequencer.
	always_comb begin
		next_cfg.heat_enable = regs[A_HEAT_ENABLE][0];
		next_cfg.demand_src = regs[A_DEMAND_SRC][2:0];
		next_cfg.mod_sensor = regs[A_MOD_SENSOR][2:0];
		next_cfg.active_setpoint = i_tod_on ? regs[A_TOD_SETPOINT] : regs[A_SETPOINT];
		next_cfg.outdoor_reset_en = regs[A_ODR_ENABLE][0];
		next_cfg.hyst_step_en = regs[A_HYST_STEP] != RST_ZERO;
		next_cfg.ign_source = regs[A_IGN_SOURCE][1:0];
		next_cfg.term_is_igniter = regs[A_TERM_FUNC][0];
		next_cfg.igniter_half_window = regs[A_IGNITER_ON][0];
		next_cfg.pilot_type = regs[A_PILOT_TYPE][1:0];
		next_cfg.flame_sensor = regs[A_FLAME_SENSOR][1:0];
		next_cfg.lightoff_prove = regs[A_LIGHTOFF_PROVE][1:0];
		next_cfg.pilot_win_s = window_s(regs[A_PILOT_WIN], PILOT_WIN_1_S);
		next_cfg.main_win_s = window_s(regs[A_MAIN_WIN], MAIN_WIN_1_S);
		next_cfg.windows_configured = (regs[A_PILOT_WIN] != NOT_CONFIGURED)
			&& (regs[A_MAIN_WIN] != NOT_CONFIGURED);
		next_cfg.timers_configured = (regs[A_PREPURGE] != NOT_CONFIGURED)
			&& (regs[A_PREIGNITION] != NOT_CONFIGURED)
			&& (regs[A_RUN_STAB] != NOT_CONFIGURED)
			&& (regs[A_POSTPURGE] != NOT_CONFIGURED)
			&& (regs[A_IGN_FAIL_DELAY] != NOT_CONFIGURED);
		next_cfg.ilk_start_check = regs[A_ILK_CHECK][0];
		next_cfg.ilk_open_recycle = regs[A_ILK_RESP][0];
		next_cfg.main_fail_recycle = regs[A_MAIN_FAIL_RESP][0];
		next_cfg.run_fail_recycle = regs[A_RUN_FAIL_RESP][0];
		next_cfg.ign_fail_resp = regs[A_IGN_FAIL_RESP][1:0];
		unique case (regs[A_IGN_RETRIES])
			16'h0001: next_cfg.ign_retries = RETRY_CODE1;
			16'h0002: next_cfg.ign_retries = RETRY_CODE2;
			16'h0003: next_cfg.ign_retries = RETRY_CODE3;
			default: next_cfg.ign_retries = 3'h0;
		endcase
		next_cfg.retries_configured = regs[A_IGN_RETRIES] != NOT_CONFIGURED;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_cfg <= '0;
		end else begin
			o_cfg <= next_cfg;
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_srst);

	sequence s_write(logic [7:0] a, logic [15:0] d);
		i_req.valid && i_req.wr && (i_req.addr == {8'h00, a}) && (i_req.wdata == d);
	endsequence

	sequence s_refused;
		o_rsp.ack && (o_rsp.exc == EXC_VALUE);
	endsequence

	sequence s_read_reserved;
		i_req.valid && !i_req.wr && in_range && reserved;
	endsequence

	sequence s_accepted;
		o_rsp.ack && (o_rsp.exc == EXC_NONE);
	endsequence

	sequence s_bad_write;
		i_req.valid && i_req.wr && in_range && !reserved && !value_ok;
	endsequence

	AST_RESERVED_READS_ZERO: assert property (
		s_read_reserved |=> o_rsp.ack && (o_rsp.rdata == RST_ZERO) && (o_rsp.exc == EXC_NONE))
		else $error("reserved location did not read zero");

	AST_WRITE_STORED: assert property (
		(i_req.valid && i_req.wr && in_range && !reserved && value_ok)
		|=> (regs[$past(a8)] == $past(i_req.wdata)) && (o_rsp.exc == EXC_NONE))
		else $error("accepted write not stored");

	AST_ANSWER_NEXT_CYCLE: assert property (
		$past(i_srst) || (o_rsp.ack == $past(i_req.valid)))
		else $error("answer not one cycle after request");

	AST_SENSOR_ONE_REFUSED: assert property (
		s_write(A_MOD_SENSOR, 16'h0001) |=> s_refused ##0 $stable(regs[A_MOD_SENSOR]))
		else $error("undefined sensor code accepted");

	AST_SETPOINT_RANGE: assert property (
		s_write(A_SETPOINT, 16'h0515) |=> s_refused)
		else $error("setpoint above limit accepted");

	AST_TOD_SETPOINT: assert property (
		i_tod_on |=> o_cfg.active_setpoint == $past(regs[A_TOD_SETPOINT]))
		else $error("time-of-day setpoint not selected");

	AST_ENABLE_FOLLOWS: assert property (
		s_write(A_HEAT_ENABLE, 16'h0001) |=> ##1 o_cfg.heat_enable)
		else $error("heating enable not applied");

	AST_STEP_DISABLE: assert property (
		s_write(A_HYST_STEP, 16'h0000) |=> ##1 !o_cfg.hyst_step_en)
		else $error("zero step time did not disable stepping");

	AST_PILOT_WINDOW: assert property (
		(regs[A_PILOT_WIN] == 16'h0002) |=> (o_cfg.pilot_win_s == WIN_2_S))
		else $error("pilot window decode wrong");

	AST_BAD_ADDRESS: assert property (
		(i_req.valid && !in_range) |=> o_rsp.ack && (o_rsp.exc == EXC_ADDR) && (o_rsp.rdata == RST_ZERO))
		else $error("unmapped address not flagged");

	// Refused values answer with the value exception and leave storage alone.
	AST_REFUSED_KEEPS: assert property (
		s_bad_write |=> s_refused ##0 (regs[$past(a8)] == $past(regs[a8])))
		else $error("refused write changed storage");

	AST_RESERVED_WRITE: assert property (
		(i_req.valid && i_req.wr && in_range && reserved) |=> s_accepted
		##0 ((regs[A_RSVD_DF] == RST_ZERO) && (regs[A_RSVD_F5] == RST_ZERO)))
		else $error("reserved write not ignored");

	AST_IDLE_QUIET: assert property (
		!o_rsp.ack |-> (o_rsp.exc == EXC_NONE) && (o_rsp.rdata == RST_ZERO))
		else $error("answer fields set without acknowledge");

	AST_READ_RETURNS: assert property (
		(i_req.valid && !i_req.wr && in_range && !reserved)
		|=> s_accepted ##0 (o_rsp.rdata == $past(regs[a8])))
		else $error("read data differs from storage");

	AST_HEAT_DISABLE: assert property (
		s_write(A_HEAT_ENABLE, 16'h0000) |=> ##1 !o_cfg.heat_enable)
		else $error("heating disable not applied");

	AST_DEMAND_RESERVED: assert property (
		s_write(A_DEMAND_SRC, 16'h0004) |=> s_refused)
		else $error("reserved demand source accepted");

	AST_SENSOR_DECODE: assert property (
		(regs[A_MOD_SENSOR] == 16'h0004) |=> (o_cfg.mod_sensor == 3'h4))
		else $error("modulation sensor decode wrong");

	AST_SETPOINT_LOW: assert property (
		s_write(A_SETPOINT, 16'hFE6F) |=> s_refused)
		else $error("setpoint below limit accepted");

	AST_TOD_OFF: assert property (
		!i_tod_on |=> o_cfg.active_setpoint == $past(regs[A_SETPOINT]))
		else $error("normal setpoint not selected");

	AST_HYST_RANGE: assert property (
		s_write(A_ON_HYST, 16'h0515) |=> s_refused)
		else $error("hysteresis above limit accepted");

	AST_OUTDOOR_FOLLOWS: assert property (
		(regs[A_ODR_ENABLE] == 16'h0001) |=> o_cfg.outdoor_reset_en)
		else $error("outdoor reset enable not applied");

	AST_STEP_RANGE: assert property (
		s_write(A_HYST_STEP, 16'hFD21) |=> s_refused)
		else $error("step time above limit accepted");

	// Each decoded field follows its register one cycle later.
	AST_IGN_SOURCE: assert property (
		(regs[A_IGN_SOURCE] == 16'h0002) |=> (o_cfg.ign_source == 2'h2))
		else $error("ignition source decode wrong");

	AST_TERMINAL: assert property (
		(regs[A_TERM_FUNC] == 16'h0001) |=> o_cfg.term_is_igniter)
		else $error("shared terminal not given to igniter");

	AST_IGNITER_WHOLE: assert property (
		(regs[A_IGNITER_ON] == 16'h0000) |=> !o_cfg.igniter_half_window)
		else $error("igniter not on for whole window");

	AST_PILOT_TYPE: assert property (
		(regs[A_PILOT_TYPE] == 16'h0003) |=> (o_cfg.pilot_type == 2'h3))
		else $error("pilot type decode wrong");

	AST_FLAME_SENSOR: assert property (
		s_write(A_FLAME_SENSOR, 16'h0004) |=> s_refused)
		else $error("undefined flame sensor accepted");

	AST_LIGHTOFF: assert property (
		(regs[A_LIGHTOFF_PROVE] == 16'h0002) |=> (o_cfg.lightoff_prove == 2'h2))
		else $error("lightoff proving decode wrong");

	AST_TIMER_RANGE: assert property (
		s_write(A_PREPURGE, 16'hFD21) |=> s_refused)
		else $error("timer above limit accepted");

	AST_TIMERS_UNSET: assert property (
		(regs[A_PREPURGE] == NOT_CONFIGURED) |=> !o_cfg.timers_configured)
		else $error("unset timer reported as configured");

	AST_PILOT_RANGE: assert property (
		s_write(A_PILOT_WIN, 16'h0004) |=> s_refused)
		else $error("undefined pilot window accepted");

	AST_MAIN_WINDOW: assert property (
		(regs[A_MAIN_WIN] == 16'h0001) |=> (o_cfg.main_win_s == MAIN_WIN_1_S))
		else $error("main window decode wrong");

	AST_WINDOWS_UNSET: assert property (
		(regs[A_MAIN_WIN] == NOT_CONFIGURED) |=> !o_cfg.windows_configured)
		else $error("unset window reported as configured");

	AST_ILK_CHECK: assert property (
		(regs[A_ILK_CHECK] == 16'h0001) |=> o_cfg.ilk_start_check)
		else $error("interlock start check not applied");

	AST_MAIN_FAIL: assert property (
		(regs[A_MAIN_FAIL_RESP] == 16'h0001) |=> o_cfg.main_fail_recycle)
		else $error("main flame failure recycle not applied");

	AST_RUN_FAIL: assert property (
		(regs[A_RUN_FAIL_RESP] == 16'h0001) |=> o_cfg.run_fail_recycle)
		else $error("run flame failure recycle not applied");

	AST_IGN_FAIL_RESP: assert property (
		(regs[A_IGN_FAIL_RESP] == 16'h0003) |=> (o_cfg.ign_fail_resp == 2'h3))
		else $error("ignite failure response decode wrong");

	AST_RETRIES_DECODE: assert property (
		(regs[A_IGN_RETRIES] == 16'h0002) |=> (o_cfg.ign_retries == RETRY_CODE2))
		else $error("retry count decode wrong");

	AST_RETRIES_UNSET: assert property (
		(regs[A_IGN_RETRIES] == NOT_CONFIGURED)
		|=> !o_cfg.retries_configured && (o_cfg.ign_retries == 3'h0))
		else $error("unset retries reported as configured");
endmodule

//--- heat_cfg_master.sv
`timescale 1ns/100ps
module heat_cfg_master
	import burner_heat_cfg_pkg::*;
(
	// Clock
	input wire logic i_core_clk,
	// Register port
	output reg_req_s o_req,
	input wire reg_rsp_s i_rsp
);
	initial begin
		o_req = '0;
	end
	// The strobe lasts one cycle and the one-cycle answer is taken at the next falling edge.
	// Between strobes address and data are inverted so stale values never match.
	task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
			output logic [7:0] e, output logic [15:0] q, output logic ok);
		@(negedge i_core_clk);
		o_req = '{valid: 1'b1, wr: wr, addr: a, wdata: d};
		ok = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge i_core_clk);
			if (i == 0) begin
				o_req = '{valid: 1'b0, wr: ~wr, addr: ~a, wdata: ~d};
			end
			ok = (i_rsp.ack === 1'b1);
			e = i_rsp.exc;
			q = i_rsp.rdata;
		end
	endtask
endmodule

//--- test_burner_heat_config_regs.sv
`timescale 1ns/100ps
module test_burner_heat_config_regs
	import burner_heat_cfg_pkg::*;
;
	logic i_core_clk;
	logic i_srst;
	logic i_tod_on;
	reg_req_s req;
	reg_rsp_s rsp;
	heat_cfg_s cfg;
	int err_total;
	int cmp_count;
	logic [7:0] e;
	logic [15:0] q;
	burner_heat_config_regs i_dut(.i_core_clk(i_core_clk), .i_srst(i_srst), .i_req(req),
		.o_rsp(rsp), .i_tod_on(i_tod_on), .o_cfg(cfg));
	heat_cfg_master i_master(.i_core_clk(i_core_clk), .o_req(req), .i_rsp(rsp));
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
		logic ok;
		i_master.access(wr, a, d, e, q, ok);
		if (ok !== 1'b1) begin
			check("answer", 16'(ok), 16'h0001);
			finish_test();
		end
	endtask
	// Writes d expecting exception x, then reads back expecting b.
	task automatic wrr(input logic [7:0] a, input logic [15:0] d, input logic [7:0] x,
			input logic [15:0] b);
		acc(1'b1, {8'h00, a}, d);
		check("write exc", 16'(e), 16'(x));
		check("write data", q, 16'h0000);
		acc(1'b0, {8'h00, a}, 16'h0000);
		check("read data", q, b);
		check("read exc", 16'(e), 16'(EXC_NONE));
	endtask
	function automatic logic [15:0] cfg_of(input logic [7:0] a);
		case (a)
			A_HEAT_ENABLE: return 16'(cfg.heat_enable);
			A_DEMAND_SRC: return 16'(cfg.demand_src);
			A_MOD_SENSOR: return 16'(cfg.mod_sensor);
			A_ODR_ENABLE: return 16'(cfg.outdoor_reset_en);
			A_IGN_SOURCE: return 16'(cfg.ign_source);
			A_TERM_FUNC: return 16'(cfg.term_is_igniter);
			A_IGNITER_ON: return 16'(cfg.igniter_half_window);
			A_PILOT_TYPE: return 16'(cfg.pilot_type);
			A_FLAME_SENSOR: return 16'(cfg.flame_sensor);
			A_LIGHTOFF_PROVE: return 16'(cfg.lightoff_prove);
			A_ILK_CHECK: return 16'(cfg.ilk_start_check);
			A_ILK_RESP: return 16'(cfg.ilk_open_recycle);
			A_IGN_FAIL_RESP: return 16'(cfg.ign_fail_resp);
			A_MAIN_FAIL_RESP: return 16'(cfg.main_fail_recycle);
			default: return 16'(cfg.run_fail_recycle);
		endcase
	endfunction
	task automatic test_reset();
		logic [15:0] b;
		check("timers cfg", 16'(cfg.timers_configured), 16'h0000);
		check("retries cfg", 16'(cfg.retries_configured), 16'h0000);
		check("windows cfg", 16'(cfg.windows_configured), 16'h0000);
		for (int a = 8'hCF; a <= 8'hF5; a++) begin
			b = (a inside {[8'hE7:8'hEC], 8'hF0, 8'hF1}) ? NOT_CONFIGURED : RST_ZERO;
			acc(1'b0, 16'(a), 16'h0000);
			check("reset value", q, b);
		end
	endtask
	task automatic test_codes();
		logic [7:0] addrs[15] = '{8'hD0, 8'hD1, 8'hD2, 8'hD7, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4,
			8'hE6, 8'hED, 8'hEE, 8'hEF, 8'hF2, 8'hF3};
		int maxv[15] = '{1, 5, 4, 1, 2, 1, 1, 3, 3, 3, 1, 1, 3, 1, 1};
		logic [15:0] last;
		logic ok;
		for (int i = 0; i < 15; i++) begin
			for (int v = 0; v <= maxv[i] + 1; v++) begin
				ok = v <= maxv[i] && !(addrs[i] == 8'hD1 && v == 4) && !(addrs[i] == 8'hD2 && v == 1);
				last = ok ? 16'(v) : last;
				wrr(addrs[i], 16'(v), ok ? EXC_NONE : EXC_VALUE, last);
				check("decoded", cfg_of(addrs[i]), last);
			end
		end
	endtask
	task automatic test_windows();
		logic [4:0] pw[4] = '{5'h00, 5'h04, 5'h0A, 5'h0F};
		logic [4:0] mw[4] = '{5'h00, 5'h05, 5'h0A, 5'h0F};
		logic [2:0] rt[4] = '{3'h0, 3'h3, 3'h5, 3'h1};
		for (int v = 0; v < 4; v++) begin
			wrr(A_PILOT_WIN, 16'(v), EXC_NONE, 16'(v));
			wrr(A_MAIN_WIN, 16'(v), EXC_NONE, 16'(v));
			wrr(A_IGN_RETRIES, 16'(v), EXC_NONE, 16'(v));
			check("pilot win", 16'(cfg.pilot_win_s), 16'(pw[v]));
			check("main win", 16'(cfg.main_win_s), 16'(mw[v]));
			check("retries", 16'(cfg.ign_retries), 16'(rt[v]));
		end
		check("win cfg", 16'(cfg.windows_configured), 16'h0001);
		wrr(A_PILOT_WIN, 16'h0004, EXC_VALUE, 16'h0003);
		wrr(A_IGN_RETRIES, NOT_CONFIGURED, EXC_NONE, NOT_CONFIGURED);
		check("retries nc", 16'(cfg.retries_configured), 16'h0000);
	endtask
	task automatic test_ranges();
		wrr(A_SETPOINT, TEMP_MIN, EXC_NONE, TEMP_MIN);
		wrr(A_SETPOINT, 16'hFE6F, EXC_VALUE, TEMP_MIN);
		wrr(A_SETPOINT, TEMP_MAX, EXC_NONE, TEMP_MAX);
		wrr(A_SETPOINT, 16'h0515, EXC_VALUE, TEMP_MAX);
		wrr(A_OFF_HYST, 16'h0514, EXC_NONE, 16'h0514);
		wrr(A_ON_HYST, 16'h0515, EXC_VALUE, 16'h0000);
		wrr(A_P_GAIN, GAIN_MAX, EXC_NONE, GAIN_MAX);
		wrr(A_D_GAIN, 16'h03E9, EXC_VALUE, 16'h0000);
		wrr(A_PRESS_OFF_HYST, 16'h05DD, EXC_VALUE, 16'h0000);
		wrr(A_PURGE_PROVE, 16'h0003, EXC_VALUE, 16'h0000);
		wrr(A_PILOT_HOLD, 16'h0002, EXC_VALUE, 16'h0000);
		wrr(A_STANDBY_RATE, 16'hFFFF, EXC_NONE, 16'hFFFF);
		wrr(A_HYST_STEP, TIME_MAX_S, EXC_NONE, TIME_MAX_S);
		check("step en", 16'(cfg.hyst_step_en), 16'h0001);
		wrr(A_HYST_STEP, 16'hFD21, EXC_VALUE, TIME_MAX_S);
		wrr(A_HYST_STEP, 16'h0000, EXC_NONE, 16'h0000);
		check("step off", 16'(cfg.hyst_step_en), 16'h0000);
		wrr(A_PREIGNITION, 16'h0000, EXC_NONE, 16'h0000);
		wrr(A_RUN_STAB, 16'h0001, EXC_NONE, 16'h0001);
		wrr(A_POSTPURGE, 16'h0002, EXC_NONE, 16'h0002);
		wrr(A_IGN_FAIL_DELAY, 16'h0003, EXC_NONE, 16'h0003);
		wrr(A_PREPURGE, TIME_MAX_S, EXC_NONE, TIME_MAX_S);
		check("timers on", 16'(cfg.timers_configured), 16'h0001);
		wrr(A_PREPURGE, 16'hFD21, EXC_VALUE, TIME_MAX_S);
		wrr(A_PREPURGE, NOT_CONFIGURED, EXC_NONE, NOT_CONFIGURED);
		check("timers off", 16'(cfg.timers_configured), 16'h0000);
	endtask
	task automatic test_tod();
		wrr(A_SETPOINT, 16'h0100, EXC_NONE, 16'h0100);
		wrr(A_TOD_SETPOINT, 16'h0200, EXC_NONE, 16'h0200);
		check("setpoint", cfg.active_setpoint, 16'h0100);
		i_tod_on = 1'b1;
		repeat (2) @(negedge i_core_clk);
		check("tod setpoint", cfg.active_setpoint, 16'h0200);
		i_tod_on = 1'b0;
		repeat (2) @(negedge i_core_clk);
		check("setpoint", cfg.active_setpoint, 16'h0100);
	endtask
	task automatic test_reserved();
		wrr(A_HEAT_ENABLE, 16'h0001, EXC_NONE, 16'h0001);
		wrr(A_RSVD_DF, 16'h1234, EXC_NONE, 16'h0000);
		wrr(A_RSVD_F5, 16'hFFFF, EXC_NONE, 16'h0000);
		acc(1'b1, 16'h01D0, 16'h0000);
		check("far exc", 16'(e), 16'(EXC_ADDR));
		acc(1'b0, 16'h00CE, 16'h0000);
		check("below exc", 16'(e), 16'(EXC_ADDR));
		check("below data", q, 16'h0000);
		acc(1'b0, {8'h00, A_IGN_SOURCE}, 16'h0000);
		check("beside rsvd", q, 16'h0002);
		acc(1'b0, {8'h00, A_HEAT_ENABLE}, 16'h0000);
		check("after far", q, 16'h0001);
		check("after far exc", 16'(e), 16'(EXC_NONE));
	endtask
	initial begin
		err_total = 0;
		cmp_count = 0;
		i_srst = 1'b1;
		i_tod_on = 1'b0;
		repeat (4) @(negedge i_core_clk);
		i_srst = 1'b0;
		@(negedge i_core_clk);
		test_reset();
		test_codes();
		test_windows();
		test_ranges();
		test_tod();
		test_reserved();
		finish_test();
	end
endmodule
